//--- comparator_window_filter_tb_top.sv
// Self-checking bench for the comparator window filter
// Assumes the far-side model drives the pins; bench owns config levels
`timescale 1ns/1ps
module comparator_window_filter_tb_top;
   import cwf_pkg::*;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ll_rst = 1'b0, en = 1'b0, wmode = 1'b0, ext_sel = 1'b0;
   logic [2:0] cnt_v = 3'h0;
   logic [7:0] per_v = 8'h00;
   logic spd = 1'b0, lowlk = 1'b0, drv = 1'b0, ra = 1'b0, fa = 1'b0, rclr = 1'b0, fclr = 1'b0;
   logic cmp_lvl = 1'b0, win_lvl = 1'b0, smp_run = 1'b0;
   logic raw, gate, smp;
   logic [7:0] o;
   cwf_mode_e mode;
   int mismatches = 0;
   int comparisons = 0;
   cwf_analog_model cwf_analog_model_i (.core_clk_i(core_clk_i), .cmp_lvl_i(cmp_lvl),
      .win_lvl_i(win_lvl), .smp_run_i(smp_run), .raw_compare_result_o(raw),
      .window_gate_o(gate), .sample_in_o(smp));
   cwf_filter cwf_filter_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .ll_wake_rst_i(ll_rst),
      .enable_i(en), .window_mode_i(wmode), .raw_compare_result_i(raw),
      .window_gate_i(gate), .sample_in_i(smp), .external_sample_select_i(ext_sel),
      .filter_sample_count_i(cnt_v), .filter_sample_period_i(per_v), .speed_select_i(spd),
      .low_leakage_i(lowlk), .output_pin_drive_i(drv), .rising_irq_allow_i(ra),
      .falling_irq_allow_i(fa), .rising_flag_clr_i(rclr), .falling_flag_clr_i(fclr),
      .unfiltered_compare_out_o(o[0]), .filtered_compare_out_o(o[1]),
      .rising_edge_flag_o(o[2]), .falling_edge_flag_o(o[3]), .irq_o(o[4]),
      .high_speed_o(o[5]), .pin_out_o(o[6]), .pin_oe_o(o[7]), .mode_o(mode));
   initial
   begin
      forever #5 core_clk_i = ~core_clk_i;
   end
   task automatic stop_test();
      if (mismatches == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic exp, input logic got);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %b seen %b", nm, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   // Bounded wait; pins pass four synchroniser flops and the state register before any output can move
   task automatic wait_out(input int k, input logic v, input int n, input string nm);
      int i;
      i = 0;
      while (o[k] !== v && i < n)
      begin
         tick(1);
         i++;
      end
      check(nm, v, o[k]);
   endtask
   task automatic hold_out(input int k, input logic v, input int n, input string nm);
      repeat (n)
      begin
         tick(1);
         check(nm, v, o[k]);
      end
   endtask
   // Passes through the disabled setting so the filter restarts clean
   task automatic cfg(input logic w, input logic s, input logic [2:0] c, input logic [7:0] p);
      ext_sel = 1'b0;
      per_v = 8'h00;
      tick(2);
      cnt_v = c;
      wmode = w;
      tick(2);
      ext_sel = s;
      per_v = p;
      tick(2);
   endtask
   task automatic t_cont();
      cfg(1'b0, 1'b0, 3'h0, 8'h00);
      check("mode", 1'b1, mode === CWF_CONT);
      cmp_lvl = 1'b1;
      wait_out(1, 1'b1, 8, "filtered");
      check("unfiltered", 1'b1, o[0]);
      wait_out(2, 1'b1, 4, "rise_flag");
      wait_out(4, 1'b1, 2, "irq_rise");
      check("pin_oe", 1'b1, o[7]);
      check("pin_out", 1'b1, o[6]);
      rclr = 1'b1;
      tick(1);
      rclr = 1'b0;
      wait_out(4, 1'b0, 3, "irq_clr");
      cmp_lvl = 1'b0;
      wait_out(3, 1'b1, 10, "fall_flag");
      wait_out(4, 1'b1, 2, "irq_fall");
      check("rise_kept", 1'b0, o[2]);
      fclr = 1'b1;
      tick(1);
      fclr = 1'b0;
      wait_out(3, 1'b0, 3, "fall_clr");
   endtask
   task automatic t_samp();
      cfg(1'b0, 1'b0, 3'h4, 8'h02);
      check("mode_s", 1'b1, mode === CWF_SAMPLED);
      cmp_lvl = 1'b1;
      hold_out(1, 1'b0, 8, "filt_early");
      wait_out(1, 1'b1, 24, "filt_late");
      cmp_lvl = 1'b0;
      cfg(1'b0, 1'b0, 3'h0, 8'h00);
   endtask
   task automatic t_win();
      cfg(1'b1, 1'b0, 3'h0, 8'h00);
      win_lvl = 1'b1;
      cmp_lvl = 1'b1;
      wait_out(0, 1'b1, 6, "win_load");
      win_lvl = 1'b0;
      cmp_lvl = 1'b0;
      hold_out(0, 1'b1, 8, "win_hold");
      win_lvl = 1'b1;
      wait_out(0, 1'b0, 6, "win_reload");
   endtask
   task automatic t_wres();
      cfg(1'b1, 1'b0, 3'h1, 8'h03);
      check("mode_w", 1'b1, mode === CWF_WINDOWED);
      cmp_lvl = 1'b1;
      wait_out(1, 1'b1, 12, "wres_out");
      cmp_lvl = 1'b0;
      cfg(1'b1, 1'b0, 3'h3, 8'h02);
      cmp_lvl = 1'b1;
      hold_out(1, 1'b0, 4, "wfilt_early");
      wait_out(1, 1'b1, 14, "wfilt_late");
      cmp_lvl = 1'b0;
   endtask
   task automatic t_ext();
      cfg(1'b0, 1'b1, 3'h2, 8'h00);
      cmp_lvl = 1'b1;
      hold_out(1, 1'b0, 10, "ext_idle");
      smp_run = 1'b1;
      wait_out(1, 1'b1, 40, "ext_run");
      smp_run = 1'b0;
   endtask
   task automatic t_power();
      spd = 1'b1;
      wait_out(5, 1'b1, 3, "speed_hi");
      lowlk = 1'b1;
      wait_out(5, 1'b0, 3, "speed_ll");
      check("mode_ll", 1'b1, mode === CWF_CONT);
      lowlk = 1'b0;
      ll_rst = 1'b1;
      tick(1);
      ll_rst = 1'b0;
      tick(2);
      check("flag_wake", 1'b1, o[2]);
      ra = 1'b0;
      fa = 1'b0;
      tick(2);
      check("irq_off", 1'b0, o[4]);
      spd = 1'b0;
      wait_out(5, 1'b0, 3, "speed_lo");
      drv = 1'b0;
      wait_out(7, 1'b0, 3, "pin_oe_off");
      rst_i = 1'b1;
      tick(1);
      rst_i = 1'b0;
      tick(1);
      check("flag_rst", 1'b0, o[2]);
   endtask
   initial
   begin
      #100000;
      mismatches++;
      stop_test();
   end
   initial
   begin
      tick(6);
      rst_i = 1'b0;
      tick(1);
      check("mode_rst", 1'b1, mode === CWF_OFF);
      check("filt_rst", 1'b0, o[1]);
      en = 1'b1;
      drv = 1'b1;
      ra = 1'b1;
      fa = 1'b1;
      t_cont();
      t_samp();
      t_win();
      t_wres();
      t_ext();
      t_power();
      stop_test();
   end
endmodule // comparator_window_filter_tb_top

//--- cwf_analog_model.sv
// Far-side model: comparator core, window source and sample source
// Assumes the bench sets levels; outputs move 1 ns after the clock edge
`timescale 1ns/1ps
module cwf_analog_model
(
   input wire logic core_clk_i,
   input wire logic cmp_lvl_i,
   input wire logic win_lvl_i,
   input wire logic smp_run_i,
   output logic raw_compare_result_o,
   output logic window_gate_o,
   output logic sample_in_o
);
   logic [2:0] div_ff;
   initial
   begin
      raw_compare_result_o = 1'b0;
      window_gate_o = 1'b0;
      sample_in_o = 1'b0;
      div_ff = 3'h0;
   end
   // Sample source idles low when stopped; slow ticks survive the pin synchroniser
   always @(posedge core_clk_i)
   begin
      div_ff <= #1 smp_run_i ? div_ff + 3'h1 : 3'h0;
      sample_in_o <= #1 smp_run_i & div_ff[2];
      raw_compare_result_o <= #1 cmp_lvl_i;
      window_gate_o <= #1 win_lvl_i;
   end
endmodule // cwf_analog_model

//--- cwf_defs.svh
// Constants for the comparator window filter block
// Assumes inclusion by the filter and synchroniser files of the block
`ifndef CWF_DEFS_SVH
`define CWF_DEFS_SVH
`define CWF_CNT_W 3
`define CWF_PER_W 8
`define CWF_CNT_BYPASS 3'h0
`define CWF_CNT_ONE 3'h1
`define CWF_PER_ZERO 8'h00
`define CWF_SYNC_RST 3'h0
`endif

//--- cwf_filter.sv
// Digital post-processing behind the analog comparator
// Assumes raw result, window and sample are pins; software owns config ports
`timescale 1ns/1ps
`include "cwf_defs.svh"
// How it works
// [R1] Sampled modes skip window, capture raw value on each filter clock edge
// [R2] Filter active when count nonzero and period nonzero, or external in sampled mode
// [R3] Windowed: unfiltered output loads while window high, holds when low
// [R4] Windowed unfiltered output trails synchronised compare input by at most one cycle
// [R5] Windowed resample takes gated value every period cycles; software sets count one
// [R6] Windowed filtered latency within one plus count times period plus one
// [R7] Wait states change nothing; block keeps running and may wake core
// [R8] Stop: enabled flag interrupt wakes chip; pin keeps driving when allowed
// [R9] Stop: speed output follows speed select
// [R10] Reset out of stop returns everything to reset values
// [R11] Low leakage: low speed, only continuous path, pin latched
// [R12] Wake from low leakage resets block but keeps edge flags
// [R13] Debug halt changes nothing
// [R14] Filtered output starts at zero until filter stages fill
// [R15] Flags come from synchronised output with edge detection
// [R16] Divided clock samples every period bus cycles
// [R17] Output changes only after count consecutive agreeing samples
// [R18] External off and period zero disables and clears filter
// [R19] Software disables filter before changing its parameters
// [R20] External mode samples on each rising sample input edge
// [R21] Noise restarts the agreement count
// [R22] Continuous mode: both outputs follow raw result
// [R23] Interrupt while a flag and its allow bit are both set
// [R24] Rising flag on 0-to-1, falling flag on 1-to-0 of synced output
module cwf_filter
#(
   parameter int CNT_W = `CWF_CNT_W,
   parameter int PER_W = `CWF_PER_W
)
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic ll_wake_rst_i,
   input wire logic enable_i,
   input wire logic window_mode_i,
   input wire logic raw_compare_result_i,
   input wire logic window_gate_i,
   input wire logic sample_in_i,
   input wire logic external_sample_select_i,
   input wire logic [CNT_W-1:0] filter_sample_count_i,
   input wire logic [PER_W-1:0] filter_sample_period_i,
   input wire logic speed_select_i,
   input wire logic low_leakage_i,
   input wire logic output_pin_drive_i,
   input wire logic rising_irq_allow_i,
   input wire logic falling_irq_allow_i,
   input wire logic rising_flag_clr_i,
   input wire logic falling_flag_clr_i,
   output logic unfiltered_compare_out_o,
   output logic filtered_compare_out_o,
   output logic rising_edge_flag_o,
   output logic falling_edge_flag_o,
   output logic irq_o,
   output logic high_speed_o,
   output logic pin_out_o,
   output logic pin_oe_o,
   output cwf_pkg::cwf_mode_e mode_o
);
   import cwf_pkg::*;
   typedef struct packed
   {
      logic unfiltered_compare_out;
      logic filtered_compare_out;
      logic [CNT_W-1:0] agree;
      logic [PER_W-1:0] div;
      logic samp_prev;
      logic sync_prev;
      logic rflag;
      logic fflag;
      logic irq;
      logic hs;
      logic pin;
      logic oe;
      cwf_mode_e mode;
      logic out_c;
   } cwf_state_s;
   cwf_state_s st_ff;
   cwf_state_s nxt_st;
   logic raw_s;
   logic win_s;
   logic samp_s;
   logic filt_on;
   logic tick;
   logic cand;
   logic filtered_compare_out_now;
   logic unfiltered_compare_out_now;

   // Three-stage synchronisers for pin inputs
   cwf_sync u_sync_raw
   (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .async_i(raw_compare_result_i),
      .sync_o(raw_s)
   );
   cwf_sync u_sync_win
   (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .async_i(window_gate_i),
      .sync_o(win_s)
   );
   cwf_sync u_sync_smp
   (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .async_i(sample_in_i),
      .sync_o(samp_s)
   );

   function automatic cwf_mode_e decode_mode(input logic en, input logic we,
      input logic se, input logic [CNT_W-1:0] cnt, input logic [PER_W-1:0] per,
      input logic ll);
      cwf_mode_e m;
      m = CWF_CONT;
      if (!en)
      begin
         m = CWF_OFF;
      end
      else if (ll)
      begin
         m = CWF_CONT; // [R11]
      end
      else if (we)
      begin
         m = CWF_WINDOWED;
      end
      else if (cnt != CNT_W'(`CWF_CNT_BYPASS) && (se || per != `CWF_PER_ZERO))
      begin
         m = CWF_SAMPLED;
      end
      return m;
   endfunction

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.mode = decode_mode(enable_i, window_mode_i, external_sample_select_i,
         filter_sample_count_i, filter_sample_period_i, low_leakage_i);
      // Filter runs only off the continuous path; period zero and no external clears it
      filt_on = (st_ff.mode == CWF_SAMPLED) || (st_ff.mode == CWF_WINDOWED
         && filter_sample_count_i != CNT_W'(`CWF_CNT_BYPASS)
         && filter_sample_period_i != `CWF_PER_ZERO); // [R2] [R18]
      tick = 1'b0;
      nxt_st.samp_prev = samp_s;
      if (!filt_on)
      begin
         nxt_st.div = '0; // [R18]
         nxt_st.agree = '0;
         nxt_st.filtered_compare_out = 1'b0; // [R14]
      end
      else if (external_sample_select_i && st_ff.mode == CWF_SAMPLED)
      begin
         tick = samp_s && !st_ff.samp_prev; // [R20] [R1]
      end
      else
      begin
         // Divider counts period bus cycles between samples
         if (st_ff.div + PER_W'(1) >= filter_sample_period_i)
         begin
            nxt_st.div = '0;
            tick = 1'b1; // [R16] [R5]
         end
         else
         begin
            nxt_st.div = st_ff.div + PER_W'(1);
         end
      end
      // Window gating loads unfiltered_compare_out only while gate high
      if (st_ff.mode == CWF_WINDOWED)
      begin
         if (win_s)
         begin
            nxt_st.unfiltered_compare_out = raw_s; // [R3] [R4]
         end
      end
      else
      begin
         nxt_st.unfiltered_compare_out = raw_s; // [R1]
      end
      cand = (st_ff.mode == CWF_WINDOWED) ? st_ff.unfiltered_compare_out : raw_s;
      if (filt_on && tick)
      begin
         if (filter_sample_count_i <= CNT_W'(`CWF_CNT_ONE))
         begin
            nxt_st.filtered_compare_out = cand; // [R5]
         end
         else if (cand == st_ff.filtered_compare_out)
         begin
            nxt_st.agree = '0; // [R21]
         end
         else if (st_ff.agree + CNT_W'(1) >= filter_sample_count_i)
         begin
            nxt_st.filtered_compare_out = cand; // [R17] [R6]
            nxt_st.agree = '0;
         end
         else
         begin
            nxt_st.agree = st_ff.agree + CNT_W'(1);
         end
      end
      unfiltered_compare_out_now = (st_ff.mode == CWF_WINDOWED) ? st_ff.unfiltered_compare_out : raw_s;
      case (st_ff.mode)
         CWF_CONT: filtered_compare_out_now = raw_s; // [R22]
         CWF_OFF: filtered_compare_out_now = 1'b0;
         default: filtered_compare_out_now = filt_on ? st_ff.filtered_compare_out : unfiltered_compare_out_now;
      endcase
      nxt_st.out_c = filtered_compare_out_now; // [R15]
      nxt_st.unfiltered_compare_out = (st_ff.mode == CWF_OFF) ? 1'b0 : nxt_st.unfiltered_compare_out;
      // Edge detect on registered output; set beats clear
      nxt_st.sync_prev = st_ff.out_c;
      nxt_st.rflag = (st_ff.rflag && !rising_flag_clr_i)
         || (st_ff.out_c && !st_ff.sync_prev); // [R24] [R15]
      nxt_st.fflag = (st_ff.fflag && !falling_flag_clr_i)
         || (!st_ff.out_c && st_ff.sync_prev); // [R24]
      nxt_st.irq = (nxt_st.rflag && rising_irq_allow_i)
         || (nxt_st.fflag && falling_irq_allow_i); // [R23] [R7] [R8] [R13]
      nxt_st.hs = speed_select_i && !low_leakage_i; // [R9] [R11]
      nxt_st.oe = output_pin_drive_i; // [R8]
      if (!low_leakage_i)
      begin
         nxt_st.pin = filtered_compare_out_now; // [R11]
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         st_ff <= '0; // [R10]
         st_ff.mode <= CWF_OFF;
      end
      else if (ll_wake_rst_i)
      begin
         st_ff <= '0; // [R12]
         st_ff.mode <= CWF_OFF;
         st_ff.rflag <= st_ff.rflag;
         st_ff.fflag <= st_ff.fflag;
         // Kept flags still request service after wake
         st_ff.irq <= (st_ff.rflag && rising_irq_allow_i) || (st_ff.fflag && falling_irq_allow_i);
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign unfiltered_compare_out_o = st_ff.unfiltered_compare_out;
   assign filtered_compare_out_o = st_ff.out_c;
   assign rising_edge_flag_o = st_ff.rflag;
   assign falling_edge_flag_o = st_ff.fflag;
   assign irq_o = st_ff.irq;
   assign high_speed_o = st_ff.hs;
   assign pin_out_o = st_ff.pin;
   assign pin_oe_o = st_ff.oe;
   assign mode_o = st_ff.mode;

   // Assertions
   AST_IRQ: assert property (@(posedge core_clk_i) disable iff (rst_i || ll_wake_rst_i) // [R23]
      (nxt_st.rflag && rising_irq_allow_i) |=> irq_o)
      else $error("irq cause lost");

   AST_FIRQ: assert property (@(posedge core_clk_i) disable iff (rst_i || ll_wake_rst_i) // [R23]
      (nxt_st.fflag && falling_irq_allow_i) |=> irq_o)
      else $error("falling irq cause lost");

   AST_OE: assert property (@(posedge core_clk_i) disable iff (rst_i || ll_wake_rst_i) // [R8]
      output_pin_drive_i |=> pin_oe_o)
      else $error("pin enable dropped");

   AST_HSPD: assert property (@(posedge core_clk_i) disable iff (rst_i || ll_wake_rst_i) // [R9]
      (speed_select_i && !low_leakage_i) |=> high_speed_o)
      else $error("high speed not selected");

   AST_CONT: assert property (@(posedge core_clk_i) disable iff (rst_i || ll_wake_rst_i) // [R22]
      (st_ff.mode == CWF_CONT) |=> filtered_compare_out_o == $past(raw_s))
      else $error("continuous output not following raw");

   AST_CLR: assert property (@(posedge core_clk_i) disable iff (rst_i || ll_wake_rst_i) // [R24]
      (rising_flag_clr_i && !(st_ff.out_c && !st_ff.sync_prev)) |=> !rising_edge_flag_o)
      else $error("rising flag not cleared");

   AST_FLT0: assert property (@(posedge core_clk_i) disable iff (rst_i || ll_wake_rst_i) // [R14]
      !filt_on |=> st_ff.filtered_compare_out == 1'b0)
      else $error("filter not restarted at zero");

   // Without a sample edge the filter must not move
   AST_EXT: assert property (@(posedge core_clk_i) disable iff (rst_i || ll_wake_rst_i) // [R20]
      (filt_on && external_sample_select_i && st_ff.mode == CWF_SAMPLED
      && !(samp_s && !st_ff.samp_prev)) |=> $stable(st_ff.filtered_compare_out))
      else $error("filter moved without sample edge");

   AST_LLMODE: assert property (@(posedge core_clk_i) disable iff (rst_i || ll_wake_rst_i) // [R11]
      (low_leakage_i && enable_i) |=> mode_o == CWF_CONT)
      else $error("low leakage left continuous path");

   AST_IRQ_TIE: assert property (@(posedge core_clk_i) disable iff (rst_i || ll_wake_rst_i) // [R23]
      irq_o == ((rising_edge_flag_o && $past(rising_irq_allow_i))
         || (falling_edge_flag_o && $past(falling_irq_allow_i))))
      else $error("irq not tied to flags");
   AST_RISE: assert property (@(posedge core_clk_i) disable iff (rst_i || ll_wake_rst_i) // [R24]
      (st_ff.out_c && !st_ff.sync_prev) |=> rising_edge_flag_o)
      else $error("rising edge missed");
   AST_FALL: assert property (@(posedge core_clk_i) disable iff (rst_i || ll_wake_rst_i) // [R24]
      (!st_ff.out_c && st_ff.sync_prev) |=> falling_edge_flag_o)
      else $error("falling edge missed");
   AST_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i || ll_wake_rst_i) // [R3]
      (st_ff.mode == CWF_WINDOWED && mode_o == $past(mode_o) && !win_s) |=> $stable(st_ff.unfiltered_compare_out))
      else $error("unfiltered_compare_out moved with gate low");
   AST_LLSPD: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R11]
      low_leakage_i |=> !high_speed_o)
      else $error("high speed in low leakage");
   AST_PIN: assert property (@(posedge core_clk_i) disable iff (rst_i || ll_wake_rst_i) // [R11]
      low_leakage_i |=> $stable(pin_out_o))
      else $error("pin moved in low leakage");
   AST_OFF: assert property (@(posedge core_clk_i) disable iff (rst_i || ll_wake_rst_i) // [R18]
      (!filt_on && st_ff.mode != CWF_CONT) |=> st_ff.agree == '0 && st_ff.div == '0)
      else $error("filter not cleared");
   AST_AGREE: assert property (@(posedge core_clk_i) disable iff (rst_i || ll_wake_rst_i) // [R17]
      (filt_on && st_ff.mode == $past(st_ff.mode) && $changed(st_ff.filtered_compare_out) && st_ff.filtered_compare_out)
      |-> $past(tick))
      else $error("filter output moved without sample");
endmodule // cwf_filter

//--- cwf_pkg.sv
// Types for the comparator window filter block
// Assumes cwf_defs.svh is on the include path
package cwf_pkg;
   typedef enum logic [1:0] {
      CWF_CONT = 2'b00,
      CWF_SAMPLED = 2'b01,
      CWF_WINDOWED = 2'b10,
      CWF_OFF = 2'b11
   } cwf_mode_e;
   typedef logic [2:0] cwf_sync_t;
endpackage

//--- cwf_sync.sv
// Three-stage synchroniser for pin inputs
// Assumes one clock; output changes once stages two and three agree
`timescale 1ns/1ps
`include "cwf_defs.svh"
module cwf_sync
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic async_i,
   output logic sync_o
);
   import cwf_pkg::*;
   typedef struct packed
   {
      cwf_sync_t stages;
      logic out;
   } cwf_sync_s;
   cwf_sync_s st_ff;
   cwf_sync_s nxt_st;
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.stages = {st_ff.stages[1:0], async_i};
      // First stage read only by the second
      if (st_ff.stages[1] == st_ff.stages[2])
      begin
         nxt_st.out = st_ff.stages[2];
      end
   end
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end
   assign sync_o = st_ff.out;
endmodule // cwf_sync
